// ===== verilog/sfh_pkg.sv
// Constants and carrier types shared by the sequencer flag and header decode block.
package sfh_pkg;

    // Instruction memory depth in 16-bit words.
    localparam int IMEM_DEPTH = 16;
    localparam int IMEM_AW = 4;
    localparam logic [IMEM_AW:0] PC_END = (IMEM_AW + 1)'(IMEM_DEPTH);
    localparam logic [IMEM_AW:0] PC_RESET = '0;

    // Update-rate divider: the fastest rate is divided down by powers of two.
    localparam int CORE_CLK_HZ = 25_000_000;
    localparam int BASE_RATE_HZ = 500_000;
    localparam int BASE_DIV = CORE_CLK_HZ / BASE_RATE_HZ;
    localparam logic [9:0] BASE_DIV_CNT = 10'(BASE_DIV);

    // Header opcodes.
    localparam logic [1:0] OP_HALT = 2'h0;
    localparam logic [1:0] OP_REST = 2'h1;
    localparam logic [1:0] OP_CHARGE = 2'h2;
    localparam logic [1:0] OP_DISCHARGE = 2'h3;

    // Debug error codes.
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_MALFORMED = 2'h1;
    localparam logic [1:0] ERR_DIV_ZERO = 2'h2;

    localparam logic [7:0] LOOP_CNT_RESET = 8'h00;

    // Header word, most significant bit first.
    typedef struct packed {
        logic time_limit_kind;
        logic user_event;
        logic gain_set_select;
        logic voltage_source_select;
        logic repeat_end;
        logic repeat_begin;
        logic switch_pin_value;
        logic ramp_enable;
        logic auto_diode_mode_enable;
        logic limit_end_disable;
        logic constant_resistance_mode;
        logic constant_power_mode;
        logic constant_current_mode;
        logic constant_voltage_mode;
        logic [1:0] opcode_field;
    } sfh_header_t;

    typedef struct packed {
        logic instruction_finished_flag;
        logic sequence_finished_flag;
        logic time_limit_flag;
        logic voltage_overrange_flag;
        logic current_overrange_flag;
        logic user_event_flag;
        logic instruction_fault_flag;
        logic loop_handover_flag;
    } sfh_flags_t;

    localparam sfh_flags_t FLAGS_RESET = '0;

    typedef struct packed {
        logic [15:0] low;
        logic [15:0] high;
    } sfh_range_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_PAYLOAD,
        ST_EXEC,
        ST_HALTED
    } sfh_state_t;

endpackage : sfh_pkg

// ===== verilog/sfh_range_watch.sv
// Consecutive out-of-range sample counter for one measurement channel.
module sfh_range_watch
    import sfh_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic sample_valid,
    input wire logic [15:0] sample,
    input wire sfh_range_t range,
    input wire logic [7:0] needed,
    output logic hit
);

    typedef struct packed {
        logic [7:0] run;
        logic hit;
    } sfh_watch_t;

    sfh_watch_t s;
    sfh_watch_t next_s;
    logic outside;
    logic [7:0] target;

    assign outside = (sample < range.low) || (sample > range.high);
    // A count of zero is treated as one so the detector can never be disabled by accident.
    assign target = (needed == 8'h00) ? 8'h01 : needed;
    assign hit = s.hit;

    always_comb begin
        next_s = s;
        next_s.hit = 1'b0;
        if (sample_valid) begin
            if (outside) begin
                if (s.run != 8'hff) begin
                    next_s.run = s.run + 8'h01;
                end
                next_s.hit = (s.run + 8'h01) == target;
            end else begin
                next_s.run = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    range_hit_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (sample_valid && outside && (s.run + 8'h01) == target) |=> hit)
        else $error("Range hit missed after the required run.");

    range_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (sample_valid && !outside) |=> (!hit && s.run == 8'h00))
        else $error("In-range sample did not reset the run.");

endmodule : sfh_range_watch

// ===== verilog/sfh_sequencer.sv
// Per-channel sequencer: instruction fetch, header decode and status flags.
//
// Operation
// - Flags stay set until status read; masked irq.
// - Finished flag on last limit or rest timeout.
// - Auto clears finished on load; manual by start.
// - Sequence flag only in auto; manual start clears it.
// - Halt or pointer past memory ends sequence.
// - Timeout error flag when no other end.
// - Over-range after consecutive out-of-threshold raw samples.
// - User event flag after flagged instruction completes.
// - Fault flag plus readable error code.
// - Handover flag on control mode change.
// - Global update rate 500 to 62.5 kHz.
// - Over-range switches the channel off.
// - Sixteen-bit words, header then payload words.
// - Low two bits opcode; mode bits select loops.
// - Limit disable ignores limits, hides over-range flags.
// - Auto diode bit enables asynchronous rectification.
// - Time limit kind: normal end or error.
// - Ramp bit ramps target instead of stepping.
// - Switch bit drives selected general purpose output.
// - Repeat begin stores address, loads empty counter.
// - Repeat end decrements, jumps back while nonzero.
// - Voltage source bit picks battery or capacitor.
// - Opcode zero halts, one rests; halt drives low.
// - Header bit layout as packed header type.
module sfh_sequencer
    import sfh_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic auto_mode,
    input wire logic start,
    input wire logic status_read,
    input wire sfh_flags_t channel_irq_mask,
    input wire logic imem_write,
    input wire logic [IMEM_AW-1:0] imem_addr,
    input wire logic [15:0] imem_data,
    input wire logic [1:0] rate_select,
    input wire logic [1:0] switch_select,
    input wire logic last_limit_hit,
    input wire logic time_limit_hit,
    input wire logic divide_by_zero,
    input wire logic loop_in_control,
    input wire logic adc_valid,
    input wire logic [15:0] measured_voltage,
    input wire logic [15:0] measured_current,
    input wire sfh_range_t voltage_range,
    input wire sfh_range_t current_range,
    input wire logic [7:0] overrange_count,
    output sfh_flags_t flags,
    output logic irq,
    output logic [1:0] error_code,
    output sfh_header_t header,
    output logic halt_drive_low,
    output logic [3:0] switch_pins,
    output logic update_tick,
    output logic channel_off
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        sfh_state_t st;
        logic [IMEM_DEPTH-1:0][15:0] mem;
        logic [IMEM_AW:0] pc;
        sfh_header_t hdr;
        logic [3:0] pay_left;
        logic first_pay;
        logic [7:0] loop_cnt;
        logic [IMEM_AW:0] loop_addr;
        logic ctrl_prev;
        sfh_flags_t flags;
        logic irq;
        logic [1:0] err;
        logic drive_low;
        logic [3:0] switch_pins;
        logic [9:0] div_cnt;
        logic tick;
        logic channel_off;
    } sfh_seq_t;

    sfh_seq_t s;
    sfh_seq_t next_s;
    logic v_ovr;
    logic i_ovr;

    assign flags = s.flags;
    assign irq = s.irq;
    assign error_code = s.err;
    assign header = s.hdr;
    assign halt_drive_low = s.drive_low;
    assign switch_pins = s.switch_pins;
    assign update_tick = s.tick;
    assign channel_off = s.channel_off;

    ////////////////////////////////////////////////////////////////////////////
    // Over-range detectors.

    sfh_range_watch u_volt_watch (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sample_valid(adc_valid),
        .sample(measured_voltage),
        .range(voltage_range),
        .needed(overrange_count),
        .hit(v_ovr)
    );

    sfh_range_watch u_curr_watch (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sample_valid(adc_valid),
        .sample(measured_current),
        .range(current_range),
        .needed(overrange_count),
        .hit(i_ovr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Payload words that follow a header; the time limit word is always present.
    function automatic logic [3:0] pay_len(input sfh_header_t h);
        logic [3:0] len;
        len = 4'h1;
        if (h.repeat_begin) begin
            len = len + 4'h1;
        end
        if (h.opcode_field[1]) begin
            if (h.constant_current_mode) begin
                len = len + 4'h2;
            end
            if (h.constant_voltage_mode) begin
                len = len + 4'h2;
            end
            if (h.constant_power_mode) begin
                len = len + 4'h1;
            end
            if (h.constant_resistance_mode) begin
                len = len + 4'h1;
            end
        end
        return len;
    endfunction : pay_len

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        sfh_flags_t set;
        sfh_header_t h;
        logic [7:0] dec;
        logic time_norm;
        logic limit_end;
        logic done;
        set = FLAGS_RESET;
        h = s.hdr;
        dec = s.loop_cnt - 8'h01;
        time_norm = 1'b0;
        limit_end = 1'b0;
        done = 1'b0;
        next_s = s;
        next_s.tick = 1'b0;

        // One divider serves all four rates; a slower rate only stretches the reload.
        if (s.div_cnt == 10'h000) begin
            next_s.div_cnt = 10'((BASE_DIV_CNT << rate_select) - 10'h001);
            next_s.tick = 1'b1;
        end else begin
            next_s.div_cnt = s.div_cnt - 10'h001;
        end

        if (imem_write) begin
            next_s.mem[imem_addr] = imem_data;
        end

        // Clears first, so that any set below wins over them.
        if (status_read) begin
            next_s.flags = FLAGS_RESET;
        end

        // The hard limit acts on the detector alone; the header only hides the flag.
        if (v_ovr || i_ovr) begin
            next_s.channel_off = 1'b1;
        end
        if (!s.hdr.limit_end_disable) begin
            set.voltage_overrange_flag = v_ovr;
            set.current_overrange_flag = i_ovr;
        end

        case (s.st)
            ST_IDLE, ST_HALTED: begin
                if (start) begin
                    if (!auto_mode) begin
                        next_s.flags.instruction_finished_flag = 1'b0;
                        next_s.flags.sequence_finished_flag = 1'b0;
                    end else begin
                        next_s.pc = PC_RESET;
                        next_s.loop_cnt = LOOP_CNT_RESET;
                    end
                    next_s.err = ERR_NONE;
                    next_s.channel_off = 1'b0;
                    next_s.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (s.pc >= PC_END) begin
                    set.sequence_finished_flag = auto_mode;
                    next_s.st = ST_IDLE;
                end else begin
                    h = s.mem[s.pc[IMEM_AW-1:0]];
                    next_s.hdr = h;
                    if (auto_mode) begin
                        next_s.flags.instruction_finished_flag = 1'b0;
                    end
                    if (h.opcode_field == OP_HALT) begin
                        set.sequence_finished_flag = auto_mode;
                        next_s.st = ST_HALTED;
                    end else if (h.opcode_field[1] && !(h.constant_current_mode || h.constant_voltage_mode ||
                                 h.constant_power_mode || h.constant_resistance_mode)) begin
                        set.instruction_fault_flag = 1'b1;
                        next_s.err = ERR_MALFORMED;
                        next_s.st = ST_IDLE;
                    end else begin
                        next_s.switch_pins[switch_select] = h.switch_pin_value;
                        if (h.repeat_begin) begin
                            next_s.loop_addr = s.pc;
                        end
                        next_s.pay_left = pay_len(h);
                        next_s.first_pay = 1'b1;
                        next_s.pc = s.pc + 5'h01;
                        next_s.st = ST_PAYLOAD;
                    end
                end
            end
            ST_PAYLOAD: begin
                if (s.pc >= PC_END) begin
                    set.sequence_finished_flag = auto_mode;
                    next_s.st = ST_IDLE;
                end else begin
                    if (s.first_pay && s.hdr.repeat_begin && s.loop_cnt == LOOP_CNT_RESET) begin
                        next_s.loop_cnt = s.mem[s.pc[IMEM_AW-1:0]][7:0];
                    end
                    next_s.first_pay = 1'b0;
                    next_s.pc = s.pc + 5'h01;
                    next_s.pay_left = s.pay_left - 4'h1;
                    next_s.ctrl_prev = loop_in_control;
                    if (s.pay_left == 4'h1) begin
                        next_s.st = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                next_s.ctrl_prev = loop_in_control;
                if (s.hdr.opcode_field[1] && loop_in_control != s.ctrl_prev) begin
                    set.loop_handover_flag = 1'b1;
                end
                // Limits never end a rest, and are ignored when the header disables them.
                limit_end = last_limit_hit && !s.hdr.limit_end_disable && s.hdr.opcode_field[1];
                time_norm = time_limit_hit && (!s.hdr.time_limit_kind || s.hdr.opcode_field == OP_REST);
                if (divide_by_zero) begin
                    set.instruction_fault_flag = 1'b1;
                    next_s.err = ERR_DIV_ZERO;
                    next_s.st = ST_IDLE;
                end else if (limit_end || time_norm) begin
                    set.instruction_finished_flag = 1'b1;
                    done = 1'b1;
                end else if (time_limit_hit) begin
                    set.time_limit_flag = 1'b1;
                    done = 1'b1;
                end
                if (done) begin
                    set.user_event_flag = s.hdr.user_event;
                    if (s.hdr.repeat_end && s.loop_cnt != LOOP_CNT_RESET) begin
                        next_s.loop_cnt = dec;
                        if (dec != LOOP_CNT_RESET) begin
                            next_s.pc = s.loop_addr;
                        end
                    end
                    next_s.st = auto_mode ? ST_FETCH : ST_IDLE;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase

        next_s.flags = next_s.flags | set;
        next_s.irq = |(next_s.flags & channel_irq_mask);
        // Bridge drive is released only while a charge or discharge executes.
        next_s.drive_low = (next_s.st != ST_EXEC) || !next_s.hdr.opcode_field[1];
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    clear_on_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (status_read && s.st == ST_IDLE && !start && !v_ovr && !i_ovr) |=> (flags == FLAGS_RESET))
        else $error("Status read did not clear the flags.");

    limit_finish_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (s.st == ST_EXEC && last_limit_hit && s.hdr.opcode_field[1] && !s.hdr.limit_end_disable &&
         !divide_by_zero) |=> flags.instruction_finished_flag)
        else $error("Last limit did not set the finished flag.");

    manual_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!auto_mode && start && (s.st == ST_IDLE || s.st == ST_HALTED)) |=>
        (!flags.instruction_finished_flag && !flags.sequence_finished_flag))
        else $error("Manual start did not clear the finished flags.");

    manual_no_seq_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!auto_mode && !flags.sequence_finished_flag) |=> !flags.sequence_finished_flag)
        else $error("Sequence flag set in manual mode.");

    halt_stop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (auto_mode && s.st == ST_FETCH && s.pc < PC_END && s.mem[s.pc[IMEM_AW-1:0]][1:0] == OP_HALT) |=>
        (flags.sequence_finished_flag && halt_drive_low && $stable(s.pc)) ##1 halt_drive_low)
        else $error("Halt did not stop the sequence with drive low.");

    rest_set_wins_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (status_read && s.st == ST_EXEC && s.hdr.opcode_field == OP_REST && time_limit_hit &&
         !divide_by_zero) |=> flags.instruction_finished_flag)
        else $error("Rest timeout lost against a clearing read.");

    timeout_err_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (s.st == ST_EXEC && time_limit_hit && s.hdr.time_limit_kind && s.hdr.opcode_field[1] &&
         !(last_limit_hit && !s.hdr.limit_end_disable) && !divide_by_zero) |=> flags.time_limit_flag)
        else $error("Timeout error flag missing.");

    div_fault_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (s.st == ST_EXEC && divide_by_zero) |=> (flags.instruction_fault_flag && error_code == ERR_DIV_ZERO))
        else $error("Divide fault not reported.");

    handover_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (s.st == ST_EXEC && s.hdr.opcode_field[1] && loop_in_control != s.ctrl_prev) |=>
        flags.loop_handover_flag)
        else $error("Control handover not flagged.");

    irq_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) |-> (irq == |(flags & $past(channel_irq_mask))))
        else $error("Interrupt does not match masked flags.");

endmodule : sfh_sequencer

// ===== tb/sfh_host_model.sv
// Host processor model that loads instruction words, starts runs and reads the channel status register.
module sfh_host_model
    import sfh_pkg::*;
(
    input wire logic core_clk,
    output logic auto_mode,
    output logic start,
    output logic status_read,
    output sfh_flags_t channel_irq_mask,
    output logic imem_write,
    output logic [IMEM_AW-1:0] imem_addr,
    output logic [15:0] imem_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        auto_mode = 1'b1;
        start = 1'b0;
        status_read = 1'b0;
        channel_irq_mask = FLAGS_RESET;
        imem_write = 1'b0;
        imem_addr = '0;
        imem_data = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Each request lasts one cycle and moves on the falling edge, clear of the sampling edge.
    task automatic write_word(input logic [IMEM_AW-1:0] a, input logic [15:0] d);
        @(negedge core_clk);
        imem_addr = a;
        imem_data = d;
        imem_write = 1'b1;
        @(negedge core_clk);
        imem_write = 1'b0;
    endtask : write_word

    task automatic pulse_start();
        @(negedge core_clk);
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
    endtask : pulse_start

    // A read of the status register clears every flag, so the host reads only when it means to.
    task automatic read_status();
        @(negedge core_clk);
        status_read = 1'b1;
        @(negedge core_clk);
        status_read = 1'b0;
    endtask : read_status

    task automatic setup(input logic am, input logic [7:0] m);
        @(negedge core_clk);
        auto_mode = am;
        channel_irq_mask = m;
    endtask : setup
endmodule : sfh_host_model

// ===== tb/testbench.sv
// Self-checking bench for the sequencer flag and header decode block.
module testbench
    import sfh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic auto_mode, start, status_read, imem_write;
    sfh_flags_t channel_irq_mask;
    logic [IMEM_AW-1:0] imem_addr;
    logic [15:0] imem_data;
    logic [1:0] rate_select = 2'h0;
    logic [1:0] switch_select = 2'h2;
    logic last_limit_hit = 1'b0, time_limit_hit = 1'b0, divide_by_zero = 1'b0, loop_in_control = 1'b0;
    logic adc_valid = 1'b0;
    logic [15:0] measured_voltage = 16'h0000, measured_current = 16'h0000;
    sfh_range_t voltage_range = {16'h0064, 16'h00C8};
    sfh_range_t current_range = {16'h0064, 16'h00C8};
    logic [7:0] overrange_count = 8'h03;
    sfh_flags_t flags;
    sfh_header_t header;
    logic irq, halt_drive_low, update_tick, channel_off;
    logic [1:0] error_code;
    logic [3:0] switch_pins;
    int errors = 0;
    int num_checks = 0;
    int n;

    always #20 core_clk = ~core_clk;

    sfh_host_model i_host (.core_clk, .auto_mode, .start, .status_read, .channel_irq_mask, .imem_write,
        .imem_addr, .imem_data);

    sfh_sequencer i_dut (.core_clk, .reset_n, .auto_mode, .start, .status_read, .channel_irq_mask, .imem_write,
        .imem_addr, .imem_data, .rate_select, .switch_select, .last_limit_hit, .time_limit_hit, .divide_by_zero,
        .loop_in_control, .adc_valid, .measured_voltage, .measured_current, .voltage_range, .current_range,
        .overrange_count, .flags, .irq, .error_code, .header, .halt_drive_low, .switch_pins, .update_tick,
        .channel_off);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // Events are levels sampled only in execution, so one cycle high is enough.
    // It returns right after the event edge, before a following fetch can clear the finished flag.
    task automatic ev_pulse(input int ev);
        case (ev)
            1: time_limit_hit = 1'b1;
            2: last_limit_hit = 1'b1;
            3: divide_by_zero = 1'b1;
            4: loop_in_control = ~loop_in_control;
            default: ;
        endcase
        cyc(1);
        {time_limit_hit, last_limit_hit, divide_by_zero} = 3'h0;
    endtask : ev_pulse

    task automatic sample(input logic [15:0] v, input logic [15:0] i);
        measured_voltage = v;
        measured_current = i;
        adc_valid = 1'b1;
        cyc(1);
        adc_valid = 1'b0;
        cyc(1);
    endtask : sample

    task automatic run(input logic [15:0] hdr);
        i_host.write_word(4'h0, hdr);
        i_host.read_status();
        i_host.pulse_start();
    endtask : run

    // The closing last-limit pulse ends a charge or discharge still running, so the next start is not refused.
    task automatic exec_case(input logic [15:0] hdr, input int ev, input logic [7:0] m, input logic [7:0] v,
        input logic [1:0] ec);
        run(hdr);
        cyc(8);
        if (ev != 0) begin
            chk(header, hdr);
        end
        ev_pulse(ev);
        chk(16'(flags & m), 16'(v));
        if (ec != ERR_NONE) begin
            chk(16'(error_code), 16'(ec));
        end
        ev_pulse(2);
        cyc(4);
    endtask : exec_case

    task automatic gap(output int g);
        g = 0;
        do begin
            cyc(1);
            g++;
        end while (update_tick !== 1'b1 && g < 1000);
    endtask : gap

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(3);
        reset_n = 1'b1;
        cyc(1);
        i_host.write_word(4'h0, 16'h4201);
        i_host.write_word(4'h1, 16'h0005);
        i_host.pulse_start();
        cyc(3);
        chk(header, 16'h4201);
        chk(16'(switch_pins), 16'h0004);
        chk(16'(halt_drive_low), 16'h0001);
        // The clearing read lands on the same edge as the timeout, so the set must survive it.
        fork
            i_host.read_status();
            begin
                cyc(1);
                ev_pulse(1);
            end
        join
        chk(16'(flags), 16'h0084);
        cyc(1);
        chk(16'({flags[7:6], irq}), 16'h0002);
        i_host.setup(1'b1, 8'h40);
        cyc(1);
        chk(16'(irq), 16'h0001);
        i_host.read_status();
        chk(16'({flags, irq}), 16'h0000);
        exec_case(16'h800A, 1, 8'hE0, 8'h20, ERR_NONE);
        exec_case(16'h8001, 1, 8'hE0, 8'h80, ERR_NONE);
        exec_case(16'h000A, 2, 8'hE0, 8'h80, ERR_NONE);
        exec_case(16'h318E, 4, 8'h01, 8'h01, ERR_NONE);
        exec_case(16'h000A, 3, 8'h02, 8'h02, ERR_DIV_ZERO);
        exec_case(16'h0002, 0, 8'h02, 8'h02, ERR_MALFORMED);
        sample(16'h012C, 16'h0096);
        sample(16'h012C, 16'h0096);
        sample(16'h0096, 16'h0096);
        sample(16'h012C, 16'h0096);
        sample(16'h012C, 16'h0096);
        chk(16'({flags[4:3], channel_off}), 16'h0000);
        sample(16'h012C, 16'h0032);
        sample(16'h0096, 16'h0032);
        sample(16'h0096, 16'h0032);
        chk(16'({flags[4:3], channel_off}), 16'h0007);
        run(16'h0041);
        cyc(4);
        repeat (3) sample(16'h012C, 16'h0032);
        chk(16'({flags[4:3], channel_off}), 16'h0001);
        ev_pulse(1);
        cyc(4);
        // Two-pass loop: rest with repeat begin and count 2, rest with repeat end, then halt.
        i_host.write_word(4'h1, 16'h0002);
        i_host.write_word(4'h3, 16'h0801);
        run(16'h0401);
        for (int k = 0; k < 4; k++) begin
            cyc(5);
            chk(16'(flags[6]), 16'h0000);
            ev_pulse(1);
        end
        cyc(2);
        chk(16'(flags[6]), 16'h0001);
        i_host.setup(1'b0, 8'h40);
        i_host.read_status();
        i_host.pulse_start();
        cyc(6);
        chk(16'({flags[6], halt_drive_low}), 16'h0001);
        for (int r = 0; r < 4; r++) begin
            rate_select = 2'(r);
            gap(n);
            gap(n);
            gap(n);
            chk(16'(n), 16'(50 << r));
        end
        end_sim();
    end

    // The sequence needs well under ten thousand cycles, so twenty thousand marks a hang.
    initial begin
        #(40 * 20000);
        errors++;
        end_sim();
    end
endmodule : testbench
